// >>> inc/pport_consts.svh
// register offsets, field positions, reset values and timing counts of the parallel port
`ifndef PPORT_CONSTS_SVH
`define PPORT_CONSTS_SVH
`define PP_OFS_MODE      3'h0
`define PP_OFS_CNT       3'h1
`define PP_OFS_STA       3'h2
`define PP_OFS_CTL       3'h3
`define PP_OFS_DAT       3'h4
`define PP_OFS_ADR       3'h5
`define PP_BIT_NBL       2
`define PP_BIT_DIR       3
`define PP_BIT_GPI       5
`define PP_BIT_PEN       7
`define PP_MODE_RST      8'h20
`define PP_MODE_WMASK    8'haf
`define PP_CNT_RST       8'h12
`define PP_UNIT_NS       40
`define PP_CLK_NS        10
`define PP_UNIT_CYC      ((`PP_UNIT_NS + `PP_CLK_NS - 1) / `PP_CLK_NS)
`endif

// >>> inc/pport_pkg.sv
// types of the parallel port
package pport_pkg;
  typedef enum logic [1:0] {
    PP_CENTRONICS = 2'h0,
    PP_SPP        = 2'h1,
    PP_EPP        = 2'h2,
    PP_ECP        = 2'h3
  } pport_mode_e;
  typedef enum logic [2:0] {
    PS_IDLE  = 3'h0,
    PS_DELAY = 3'h1,
    PS_PULSE = 3'h3,
    PS_WAIT  = 3'h2,
    PS_IN    = 3'h6
  } pport_state_e;
endpackage : pport_pkg

// >>> rtl/pport_buf2.sv
// two-entry valid/ready buffer
`timescale 1ns/10ps
module pport_buf2 #(
  parameter int W = 9
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  logic [W-1:0] mem [2];
  logic         rd, wr;
  logic [1:0]   cnt, next_cnt;
  logic         rd_ptr, next_rd_ptr;
  logic         wr_ptr, next_wr_ptr;
  logic         push, pop;

  always_comb begin
    push        = in_valid_i && (cnt != 2'h2);
    pop         = (cnt != 2'h0) && out_ready_i;
    next_cnt    = cnt + {1'b0, push} - {1'b0, pop};
    next_rd_ptr = rd_ptr ^ pop;
    next_wr_ptr = wr_ptr ^ push;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt    <= 2'h0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  assign rd          = rd_ptr;
  assign wr          = wr_ptr;
  assign in_ready_o  = (cnt != 2'h2);
  assign out_valid_o = (cnt != 2'h0);
  assign out_data_o  = mem[rd];
endmodule : pport_buf2

// >>> rtl/pport_top.sv
// parallel port: mode control, data path and automatic strobes
`timescale 1ns/10ps
`include "pport_consts.svh"
// Behaviour
// - mode 00 drives data out only; software drives every control line
// - mode 01 runs bidirectionally with automatic handshake, nibble optional
// - ECP output sends address and data bytes with its handshake
// - EPP output sends address and data bytes with its handshake
// - EPP/ECP input places peripheral bytes in the data register
// - mode field bits 1:0 reset 00: Centronics, SPP, EPP, ECP
// - one data register serves both directions, paced by full/empty flags
// - device drives host control lines; peripheral drives status lines
// - 8-bit strobe counter, reset 12h, 40 ns units, delay and pulse width
// - nibble select bit 2, honoured only in SPP, resets 0
// - direction bit 3 for modes 1-3; 0 output, 1 input
// - general-input bit 5, reset 1, latches data bus continuously
// - transfer enable bit 7, reset 0, blocks data writes and handshakes; general input still latches
// - receive-full sets on byte in, clears on read, resets 0
// - transmit-empty clears while byte unsent, sets on accept, resets 1
module pport_top
  import pport_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [2:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [7:0]  pd_i,
  output logic [7:0]       pd_o,
  output logic             pd_oe_o,
  output logic             ctl1_o,
  output logic             ctl2_o,
  output logic             ctl3_o,
  output logic             ctl4_o,
  input  wire logic        stat_ack_i,
  input  wire logic        stat_falt_i,
  input  wire logic        stat_slct_i,
  input  wire logic        stat_per_i,
  input  wire logic        stat_busy_i
);
  logic [7:0]   port_mode_control, next_mode;
  logic [7:0]   strobe_timing_counter, next_cnt;
  logic [3:0]   sw_ctl, next_sw_ctl;
  logic [7:0]   port_data_register, next_dat;
  logic         receive_full_flag, next_rxf;
  logic         transmit_empty_flag, next_txe;
  logic [31:0]  next_rdata;
  logic         ack_q, next_ack;
  pport_state_e st, next_st;
  logic [7:0]   tmr, next_tmr;
  logic [1:0]   sub, next_sub;
  logic         is_adr, next_is_adr;
  logic         nib_hi, next_nib_hi;
  logic [7:0]   pd_q, next_pd;
  logic         oe_q, next_oe;
  logic [3:0]   ctl_q, next_ctl;
  logic         b_in_valid, b_in_ready, b_out_valid, b_out_ready;
  logic [8:0]   b_out_data;
  logic         req, wr_acc, rd_acc;
  logic         ack_d, next_ack_d, unit_end;
  pport_mode_e  mode;
  logic         dir_in, gpi, port_transfer_enable, auto_mode;

  function automatic logic [31:0] pp_zx(input logic [7:0] v);
    pp_zx = {24'h0, v};
  endfunction : pp_zx

  assign mode = pport_mode_e'(port_mode_control[1:0]);
  assign gpi  = port_mode_control[`PP_BIT_GPI];
  assign port_transfer_enable  = port_mode_control[`PP_BIT_PEN];
  assign dir_in    = port_mode_control[`PP_BIT_DIR] && (mode != PP_CENTRONICS);
  assign auto_mode = !gpi && (mode != PP_CENTRONICS);

  // answer one cycle after the request so every read comes from a flop
  assign req    = (avs_read_i || avs_write_i) && !ack_q;
  // a write lands at the edge where the master sees waitrequest low
  assign wr_acc = avs_write_i && ack_q;
  assign rd_acc = avs_read_i && !ack_q;

  // outgoing address/data bytes wait in the buffer so a slow peripheral loses none
  always_comb begin
    b_in_valid = 1'b0;
    if (wr_acc && port_transfer_enable && auto_mode && !dir_in && transmit_empty_flag) begin
      b_in_valid = (avs_address_i == `PP_OFS_DAT) ||
                   ((avs_address_i == `PP_OFS_ADR) && mode[1]);
    end
  end

  pport_buf2 #(.W(9)) u_buf (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (b_in_valid),
    .in_ready_o  (b_in_ready),
    .in_data_i   ({avs_address_i == `PP_OFS_ADR, avs_writedata_i[7:0]}),
    .out_valid_o (b_out_valid),
    .out_ready_i (b_out_ready),
    .out_data_o  (b_out_data)
  );

  // register file and flags
  always_comb begin
    next_mode   = port_mode_control;
    next_cnt    = strobe_timing_counter;
    next_sw_ctl = sw_ctl;
    next_dat    = port_data_register;
    next_rxf    = receive_full_flag;
    next_txe    = transmit_empty_flag;
    next_ack    = req;
    next_rdata  = avs_readdata_o;
    if (wr_acc) begin
      unique case (avs_address_i)
        `PP_OFS_MODE: next_mode = avs_writedata_i[7:0] & `PP_MODE_WMASK;
        `PP_OFS_CNT:  next_cnt = avs_writedata_i[7:0];
        `PP_OFS_CTL:  next_sw_ctl = avs_writedata_i[3:0];
        `PP_OFS_DAT: begin
          // writes blocked while disabled; and while transmit-empty is clear
          if (port_transfer_enable && !dir_in && !gpi && transmit_empty_flag) begin
            next_dat = avs_writedata_i[7:0];
            if (auto_mode) begin
              next_txe = 1'b0;
            end
          end
        end
        `PP_OFS_ADR: begin
          if (b_in_valid) begin
            next_txe = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // read of the byte clears receive-full
    if (rd_acc && avs_address_i == `PP_OFS_DAT) begin
      next_rxf = 1'b0;
    end
    if (st == PS_WAIT && next_st == PS_IDLE && !b_out_valid) begin
      next_txe = 1'b1;
    end
    // general input latches the bus every cycle
    if (gpi) begin
      next_dat = pd_i;
    end else if (st == PS_IN && next_st == PS_IDLE) begin
      // captured byte; set wins over clear
      next_dat = pd_i;
      next_rxf = 1'b1;
    end
    if (rd_acc) begin
      unique case (avs_address_i)
        `PP_OFS_MODE: next_rdata = pp_zx(port_mode_control);
        `PP_OFS_CNT:  next_rdata = pp_zx(strobe_timing_counter);
        `PP_OFS_STA:  next_rdata = pp_zx({stat_busy_i, !stat_ack_i, stat_per_i,
                                          stat_slct_i, !stat_falt_i, 1'b0,
                                          transmit_empty_flag, receive_full_flag});
        `PP_OFS_CTL:  next_rdata = pp_zx({4'h0, sw_ctl});
        `PP_OFS_DAT:  next_rdata = pp_zx(port_data_register);
        default:      next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port_mode_control     <= `PP_MODE_RST;
      strobe_timing_counter <= `PP_CNT_RST;
      sw_ctl                <= 4'h0;
      port_data_register    <= 8'h00;
      receive_full_flag     <= 1'b0;
      transmit_empty_flag   <= 1'b1;
      ack_q                 <= 1'b0;
      avs_readdata_o        <= 32'h0;
    end else begin
      port_mode_control     <= next_mode;
      strobe_timing_counter <= next_cnt;
      sw_ctl                <= next_sw_ctl;
      port_data_register    <= next_dat;
      receive_full_flag     <= next_rxf;
      transmit_empty_flag   <= next_txe;
      ack_q                 <= next_ack;
      avs_readdata_o        <= next_rdata;
    end
  end
  assign avs_waitrequest_o = !ack_q;

  // last clock of the counted span, so a span is exactly count units long, or one clock when count is 0
  assign unit_end = (tmr == 8'h0) || (tmr == 8'h1 && sub == 2'(`PP_UNIT_CYC - 1));

  // handshake engine; one counter unit is a few clocks
  always_comb begin
    next_st     = st;
    next_tmr    = tmr;
    next_sub    = sub;
    next_is_adr = is_adr;
    next_nib_hi = nib_hi;
    next_ack_d  = stat_ack_i;
    b_out_ready = 1'b0;
    if (tmr != 8'h0 && sub == 2'(`PP_UNIT_CYC - 1)) begin
      next_tmr = tmr - 8'h1;
    end
    next_sub = (sub == 2'(`PP_UNIT_CYC - 1)) ? 2'h0 : sub + 2'h1;
    unique case (st)
      PS_IDLE: begin
        next_nib_hi = 1'b0;
        if (port_transfer_enable && auto_mode) begin
          if (!dir_in && b_out_valid) begin
            b_out_ready = 1'b1;
            next_is_adr = b_out_data[8];
            next_st     = PS_DELAY;
            next_tmr    = strobe_timing_counter;
            next_sub    = 2'h0;
          end else if (dir_in && !receive_full_flag && !stat_ack_i) begin
            next_st = PS_IN;
          end
        end
      end
      // delay after busy before the strobe
      PS_DELAY: begin
        if (stat_busy_i) begin
          next_tmr = strobe_timing_counter;
          next_sub = 2'h0;
        end else if (unit_end) begin
          next_st  = PS_PULSE;
          next_tmr = strobe_timing_counter;
          next_sub = 2'h0;
        end
      end
      // strobe held for the counted width
      PS_PULSE: begin
        if (unit_end) begin
          next_st = PS_WAIT;
        end
      end
      PS_WAIT: begin
        if (!stat_busy_i) begin
          next_st = PS_IDLE;
        end
      end
      PS_IN: begin
        // nibble input takes two peripheral strobes; count rises, not levels
        if (stat_ack_i && !ack_d) begin
          if (mode == PP_SPP && port_mode_control[`PP_BIT_NBL] && !nib_hi) begin
            next_nib_hi = 1'b1;
            next_st     = PS_IN;
          end else begin
            next_st = PS_IDLE;
          end
        end
      end
      default: next_st = PS_IDLE;
    endcase
  end

  // pin drive
  always_comb begin
    // general input releases the bus, in Centronics too; otherwise Centronics drives
    next_oe  = !gpi && !dir_in;
    next_pd  = (st == PS_DELAY || st == PS_PULSE) ? pd_q : port_data_register;
    next_ctl = 4'h0;
    if (st == PS_IDLE && b_out_valid) begin
      next_pd = b_out_data[7:0];
    end
    // control lines per mode, active high here
    unique case (mode)
      PP_CENTRONICS: next_ctl = sw_ctl;
      PP_SPP:        next_ctl = {sw_ctl[3], sw_ctl[2], st == PS_IN, st == PS_PULSE};
      // address or data strobe, write line
      PP_EPP:        next_ctl = {(st == PS_PULSE) && is_adr, sw_ctl[2],
                                 (st == PS_PULSE) && !is_adr, !dir_in};
      // host clock, host ack marks data versus command
      PP_ECP:        next_ctl = {1'b1, dir_in, !is_adr, st == PS_PULSE};
      default:       next_ctl = 4'h0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st     <= PS_IDLE;
      tmr    <= 8'h0;
      sub    <= 2'h0;
      is_adr <= 1'b0;
      nib_hi <= 1'b0;
      ack_d  <= 1'b0;
      pd_q   <= 8'h00;
      oe_q   <= 1'b0;
      ctl_q  <= 4'h0;
    end else begin
      st     <= next_st;
      tmr    <= next_tmr;
      sub    <= next_sub;
      is_adr <= next_is_adr;
      nib_hi <= next_nib_hi;
      ack_d  <= next_ack_d;
      pd_q   <= next_pd;
      oe_q   <= next_oe;
      ctl_q  <= next_ctl;
    end
  end

  assign pd_o    = pd_q;
  assign pd_oe_o = oe_q;
  assign ctl1_o  = ctl_q[0];
  assign ctl2_o  = ctl_q[1];
  assign ctl3_o  = ctl_q[2];
  assign ctl4_o  = ctl_q[3];
  // buffer ready is unused; the transmit-empty gate above keeps the buffer from filling
  logic unused_ready;
  assign unused_ready = b_in_ready;
endmodule : pport_top

// >>> dv/pport_assertions.sv
// checker of bus answer timing, bus direction and strobe timing
`timescale 1ns/10ps
`include "pport_consts.svh"
module pport_assertions (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [2:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        pd_oe_o,
  input wire logic        ctl1_o,
  input wire logic        stat_busy_i
);
  logic [7:0]  mode, next_mode, mode_d1, mode_d2, cnt, next_cnt;
  logic [10:0] hi, next_hi, lo, next_lo, want;
  logic        wr_done, stab, auto_ok;
  assign wr_done = avs_write_i && !avs_waitrequest_o;
  assign stab    = (mode == mode_d1) && (mode_d1 == mode_d2);
  assign auto_ok = stab && !mode[5] && !mode[3] && mode[1:0] == 2'h1;
  assign want    = {1'b0, cnt, 2'b00};
  always_comb begin
    next_mode = mode;
    next_cnt  = cnt;
    if (wr_done && avs_address_i == `PP_OFS_MODE) next_mode = avs_writedata_i[7:0] & `PP_MODE_WMASK;
    if (wr_done && avs_address_i == `PP_OFS_CNT) next_cnt = avs_writedata_i[7:0];
    next_hi = ctl1_o ? hi + 11'h1 : 11'h0;
    next_lo = stat_busy_i ? 11'h0 : (lo == 11'h7ff ? lo : lo + 11'h1);
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode    <= `PP_MODE_RST;
      mode_d1 <= `PP_MODE_RST;
      mode_d2 <= `PP_MODE_RST;
      cnt     <= `PP_CNT_RST;
      hi      <= 11'h0;
      lo      <= 11'h0;
    end else begin
      mode    <= next_mode;
      mode_d1 <= mode;
      mode_d2 <= mode_d1;
      cnt     <= next_cnt;
      hi      <= next_hi;
      lo      <= next_lo;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_taken;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_answer;
    !avs_waitrequest_o;
  endsequence
  a_wait_once: assert property (s_taken |=> s_answer)
    else $error("no answer one cycle after request");
  a_wait_stands: assert property (s_answer |=> avs_waitrequest_o)
    else $error("answer held longer than one cycle");
  a_answer_cause: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i))
    else $error("answer without request");
  a_rdata_holds: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data changed without read");
  a_gpi_input: assert property (stab && mode[5] |-> !pd_oe_o)
    else $error("bus driven in general-input mode");
  a_dir_input: assert property (stab && !mode[5] && mode[3] && mode[1:0] != 2'h0 |-> !pd_oe_o)
    else $error("bus driven in input direction");
  // strobe width counted in helper logic, too long for a repetition
  a_strobe_width: assert property (auto_ok && mode[7] && $fell(ctl1_o) |-> hi == want)
    else $error("strobe width wrong");
  a_strobe_delay: assert property (auto_ok && mode[7] && $rose(ctl1_o) |-> lo + 11'h1 >= want)
    else $error("strobe too soon after busy low");
  a_pen_blocks: assert property (auto_ok && !mode[7] |-> !$rose(ctl1_o))
    else $error("strobe while transfers disabled");
endmodule : pport_assertions

bind pport_top pport_assertions chk_u (.clk_i, .rstn_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .pd_oe_o, .ctl1_o,
  .stat_busy_i);

// >>> dv/pport_periph_model.sv
// peripheral model: takes strobed bytes, sends bytes with an ack pulse
`timescale 1ns/10ps
module pport_periph_model (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [7:0] pd_i,
  input  wire logic       strobe_i,
  output logic [7:0]      pd_o,
  output logic            ack_o,
  output logic            busy_o,
  output logic [7:0]      got_o
);
  logic       strobe_q;
  logic [1:0] hold;
  initial pd_o = 8'h00;
  initial ack_o = 1'b0;
  // busy raised on strobe, dropped late
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strobe_q <= 1'b0;
      busy_o   <= 1'b0;
      hold     <= 2'h0;
      got_o    <= 8'h00;
    end else begin
      strobe_q <= strobe_i;
      if (strobe_i && !strobe_q) begin
        got_o  <= pd_i;
        busy_o <= 1'b1;
        hold   <= 2'h3;
      end else if (busy_o && !strobe_i) begin
        if (hold != 2'h0) hold <= hold - 2'h1;
        else busy_o <= 1'b0;
      end
    end
  end
  // data and ack from the peripheral; bus shows the inverse once released
  task automatic send(input logic [7:0] b);
    pd_o <= b;
    @(posedge clk_i);
    ack_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    ack_o <= 1'b0;
    @(posedge clk_i);
    pd_o <= ~b;
  endtask : send
  task automatic hold_bus(input logic [7:0] b);
    pd_o <= b;
  endtask : hold_bus
endmodule : pport_periph_model

// >>> dv/ieee1284_parallel_port_bench.sv
// self-checking bench of the parallel port
`timescale 1ns/10ps
`include "pport_consts.svh"
module ieee1284_parallel_port_bench;
  logic        clk_i = 1'b0, rstn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [2:0]  avs_address_i = 3'h0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, d;
  logic [7:0]  pd_o, pm_pd, got;
  logic        avs_waitrequest_o, pd_oe_o, ctl1_o, ctl2_o, ctl3_o, ctl4_o, ack, busy;
  wire  [7:0]  pd_bus = pd_oe_o ? pd_o : pm_pd;
  int          num_errors = 0, check_count = 0;
  always #5 clk_i = ~clk_i;
  pport_top dut_u (.clk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .pd_i(pd_bus), .pd_o, .pd_oe_o,
    .ctl1_o, .ctl2_o, .ctl3_o, .ctl4_o, .stat_ack_i(ack), .stat_falt_i(1'b0),
    .stat_slct_i(1'b0), .stat_per_i(1'b0), .stat_busy_i(busy));
  pport_periph_model pm_u (.clk_i, .rstn_i, .pd_i(pd_bus), .strobe_i(ctl1_o), .pd_o(pm_pd),
    .ack_o(ack), .busy_o(busy), .got_o(got));
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= {24'h0, v};
    avs_write_i     <= 1'b1;
    // look between edges: the value there is what the next rising edge samples
    do @(negedge clk_i); while (avs_waitrequest_o !== 1'b0);
    @(posedge clk_i);
    avs_write_i <= 1'b0;
  endtask : wr
  task rd(input logic [2:0] a);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_read_i    <= 1'b1;
    do @(negedge clk_i); while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o;
    @(posedge clk_i);
    avs_read_i <= 1'b0;
  endtask : rd
  task poll(input int b, input logic v);
    rd(`PP_OFS_STA);
    repeat (300) if (d[b] !== v) rd(`PP_OFS_STA);
  endtask : poll
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(`PP_OFS_MODE);
    chk(d, 32'h20);
    rd(`PP_OFS_CNT);
    chk(d, 32'h12);
    rd(`PP_OFS_STA);
    chk(d, 32'h4a);
    rd(3'h7);
    chk(d, 32'h0);
    pm_u.hold_bus(8'ha5);
    rd(`PP_OFS_DAT);
    chk(d, 32'ha5);
    wr(`PP_OFS_MODE, 8'h50);
    rd(`PP_OFS_MODE);
    chk(d, 32'h00);
    $display("reset and general-input test done");
    wr(`PP_OFS_CNT, 8'h02);
    wr(`PP_OFS_MODE, 8'h01);
    wr(`PP_OFS_DAT, 8'h3c);
    rd(`PP_OFS_STA);
    chk(d[1], 1'b1);
    wr(`PP_OFS_MODE, 8'h81);
    wr(`PP_OFS_DAT, 8'hc3);
    wr(`PP_OFS_DAT, 8'h99);
    rd(`PP_OFS_STA);
    chk(d[1], 1'b0);
    poll(1, 1'b1);
    chk(d[1], 1'b1);
    chk(got, 8'hc3);
    $display("output test done");
    // every mode that takes input, ack captures the bus
    for (int m = 1; m < 4; m++) begin
      wr(`PP_OFS_MODE, 8'h88 | m[7:0]);
      pm_u.send(8'h5a ^ m[7:0]);
      poll(0, 1'b1);
      chk(d[0], 1'b1);
      rd(`PP_OFS_DAT);
      chk(d, {24'h0, 8'h5a ^ m[7:0]});
      rd(`PP_OFS_STA);
      chk(d[0], 1'b0);
    end
    $display("input test done");
    wr(`PP_OFS_MODE, 8'h8d);
    pm_u.send(8'h11);
    rd(`PP_OFS_STA);
    chk(d[0], 1'b0);
    pm_u.send(8'h6b);
    poll(0, 1'b1);
    rd(`PP_OFS_DAT);
    chk(d, 32'h6b);
    $display("nibble test done");
    wr(`PP_OFS_MODE, 8'h88);
    wr(`PP_OFS_CTL, 8'h0a);
    wr(`PP_OFS_DAT, 8'h77);
    repeat (2) @(posedge clk_i);
    chk({pd_oe_o, pd_o}, 32'h177);
    chk({ctl4_o, ctl3_o, ctl2_o, ctl1_o}, 32'ha);
    $display("manual mode test done");
    end_of_test();
  end
endmodule : ieee1284_parallel_port_bench
